// *** hdl/pwd_pkg.sv ***
// constants, register map and bus carriers for the pulse-width demodulator
package pwd_pkg;
    // clock and timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int TIMER_DIV = 4;
    localparam logic [1:0] DIV_LAST = 2'h3;
    localparam int MAX_LAG_CYC = 6;
    localparam int SYNC_STAGES = 3;
    // widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 16;
    localparam int PIN_W = 4;
    // synchronised pin positions
    localparam int PIN_PULSE = 0;
    localparam int PIN_T0 = 1;
    localparam int PIN_T1 = 2;
    localparam int PIN_HI_IRQ = 3;
    // register byte offsets
    localparam logic [7:0] OFF_SYS_CFG = 8'h00;
    localparam logic [7:0] OFF_T0_CNT = 8'h04;
    localparam logic [7:0] OFF_T0_MAX = 8'h08;
    localparam logic [7:0] OFF_T0_CTL = 8'h0c;
    localparam logic [7:0] OFF_T1_CNT = 8'h10;
    localparam logic [7:0] OFF_T1_MAX = 8'h14;
    localparam logic [7:0] OFF_T1_CTL = 8'h18;
    localparam logic [7:0] OFF_IRQ_REQ = 8'h1c;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
    localparam logic [7:0] OFF_PIO_IN = 8'h24;
    // field positions
    localparam int CFG_DEMOD_BIT = 0;
    localparam int TCTL_INT_EN_BIT = 0;
    localparam int TCTL_MC_BIT = 1;
    localparam int IRQ_LOW_END_BIT = 0;
    localparam int IRQ_HIGH_END_BIT = 1;
    localparam int IRQ_T0_MC_BIT = 2;
    localparam int IRQ_T1_MC_BIT = 3;
    localparam int IRQ_W = 4;
    localparam int PIO_W = 3;
    // reset values
    localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
    localparam logic [CNT_W-1:0] MAX_RST = 16'h0000;
    localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } pwd_apb_req_s;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [DATA_W-1:0] prdata;
    } pwd_apb_rsp_s;
endpackage : pwd_pkg

// *** hdl/pwd_sync.sv ***
// input synchroniser with registered level and edge pulses
`timescale 1ns/1ps
`default_nettype none
module pwd_sync #(
    parameter int W = 4
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // raw pins
    input wire logic [W-1:0] pin_in,
    // conditioned outputs
    output logic [W-1:0] level_out,
    output logic [W-1:0] rise_out,
    output logic [W-1:0] fall_out
);
    logic [W-1:0] s1_r, s2_r, s3_r, rise_r, fall_r;
    logic [W-1:0] rise_nxt, fall_nxt;

    always_comb begin
        rise_nxt = s2_r & ~s3_r;
        fall_nxt = ~s2_r & s3_r;
    end

    // s1 feeds only s2, so edges are judged on settled values
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            rise_r <= '0;
            fall_r <= '0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            rise_r <= rise_nxt;
            fall_r <= fall_nxt;
        end
    end

    assign level_out = s3_r;
    assign rise_out = rise_r;
    assign fall_out = fall_r;
endmodule : pwd_sync
`default_nettype wire

// *** hdl/pwd_timer.sv ***
// one 16-bit measuring timer with max-count wrap and sticky flag
`timescale 1ns/1ps
`default_nettype none
module pwd_timer
    import pwd_pkg::*;
(
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // count event and software access
    input wire logic event_in,
    input wire logic wr_cnt_in,
    input wire logic wr_max_in,
    input wire logic mc_clr_in,
    input wire logic [pwd_pkg::CNT_W-1:0] wr_data_in,
    // state
    output logic [pwd_pkg::CNT_W-1:0] count_out,
    output logic [pwd_pkg::CNT_W-1:0] max_out,
    output logic mc_out,
    output logic wrap_out
);
    logic [CNT_W-1:0] cnt_r, cnt_nxt, max_r, max_nxt, inc;
    logic mc_r, mc_nxt, wrap_r, wrap_nxt;

    always_comb begin
        inc = cnt_r + 16'h0001;
        cnt_nxt = cnt_r;
        wrap_nxt = 1'b0;
        max_nxt = wr_max_in ? wr_data_in : max_r;
        if (wr_cnt_in) begin
            cnt_nxt = wr_data_in;
        end else if (event_in) begin
            // a max of zero wraps after 65536 events
            if (inc == max_r) begin
                cnt_nxt = CNT_RST;
                wrap_nxt = 1'b1;
            end else begin
                cnt_nxt = inc;
            end
        end
        // a wrap in the clearing cycle survives
        mc_nxt = (mc_r & ~mc_clr_in) | wrap_nxt;
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_r <= CNT_RST;
            max_r <= MAX_RST;
            mc_r <= 1'b0;
            wrap_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            max_r <= max_nxt;
            mc_r <= mc_nxt;
            wrap_r <= wrap_nxt;
        end
    end

    assign count_out = cnt_r;
    assign max_out = max_r;
    assign mc_out = mc_r;
    assign wrap_out = wrap_r;

    wrap_to_zero_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (event_in && !wr_cnt_in && (inc == max_r)) |=> (cnt_r == CNT_RST) && wrap_r)
        else $error("timer did not return to zero at max count");
    max_flag_set_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        wrap_r |-> mc_r)
        else $error("max count flag missing after wrap");
endmodule : pwd_timer
`default_nettype wire

// *** hdl/pwd_top.sv ***
// pulse-width demodulator: two gated timers, edge requests, apb registers
`timescale 1ns/1ps
`default_nettype none
module pwd_top
    import pwd_pkg::*;
(
    // clock and reset
    input wire logic clock_in,
    input wire logic rst_n_in,
    // apb slave
    input wire pwd_pkg::pwd_apb_req_s apb_req_in,
    output pwd_pkg::pwd_apb_rsp_s apb_rsp_out,
    // pins
    input wire logic pulse_pin_in,
    input wire logic timer_zero_ext_input_in,
    input wire logic timer_one_ext_input_in,
    input wire logic high_phase_end_irq_in,
    // status
    output logic irq_out,
    output logic demod_active_out,
    output logic [pwd_pkg::PIO_W-1:0] programmable_io_free_out
);
    logic [PIN_W-1:0] lvl, rise, fall;
    logic [1:0] div_r, div_nxt;
    logic tick_r, tick_nxt;
    logic cfg_r, cfg_nxt;
    logic t0_ie_r, t0_ie_nxt, t1_ie_r, t1_ie_nxt;
    logic pend0_r, pend0_nxt, pend1_r, pend1_nxt;
    logic [IRQ_W-1:0] req_r, req_nxt, mask_r, mask_nxt, req_set;
    logic irq_r, irq_nxt;
    logic rdy_r, rdy_nxt, err_r, err_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic [PIO_W-1:0] pio_r, pio_nxt;
    logic acc, start, wr, hit, demod;
    logic [DATA_W-1:0] rd_mux;
    logic t0_ev, t1_ev;
    logic wr_t0_cnt, wr_t0_max, wr_t0_ctl, wr_t1_cnt, wr_t1_max, wr_t1_ctl;
    logic [CNT_W-1:0] t0_cnt, t0_max, t1_cnt, t1_max;
    logic t0_mc, t1_mc, t0_wrap, t1_wrap;
    logic low_end, high_end;

    assign demod = cfg_r;

    // three flops and the edge register keep the pin to timer lag within six cycles
    pwd_sync #(
        .W(PIN_W)
    ) u_sync (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .pin_in({high_phase_end_irq_in, timer_one_ext_input_in, timer_zero_ext_input_in, pulse_pin_in}),
        .level_out(lvl),
        .rise_out(rise),
        .fall_out(fall)
    );

    // quarter-rate service tick
    always_comb begin
        div_nxt = div_r + 2'h1;
        tick_nxt = (div_r == DIV_LAST);
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_r <= 2'h0;
            tick_r <= 1'b0;
        end else begin
            div_r <= div_nxt;
            tick_r <= tick_nxt;
        end
    end

    // timer events; in normal mode an external edge waits for the next tick, and edges in one tick window count once
    always_comb begin
        pend0_nxt = (pend0_r | rise[PIN_T0]) & ~tick_r;
        pend1_nxt = (pend1_r | rise[PIN_T1]) & ~tick_r;
        if (demod) begin
            pend0_nxt = 1'b0;
            pend1_nxt = 1'b0;
            t0_ev = tick_r & lvl[PIN_PULSE];
            t1_ev = tick_r & ~lvl[PIN_PULSE];
        end else begin
            t0_ev = tick_r & (pend0_r | rise[PIN_T0]);
            t1_ev = tick_r & (pend1_r | rise[PIN_T1]);
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pend0_r <= 1'b0;
            pend1_r <= 1'b0;
        end else begin
            pend0_r <= pend0_nxt;
            pend1_r <= pend1_nxt;
        end
    end

    pwd_timer u_t0 (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .event_in(t0_ev),
        .wr_cnt_in(wr_t0_cnt),
        .wr_max_in(wr_t0_max),
        .mc_clr_in(wr_t0_ctl & ~apb_req_in.pwdata[TCTL_MC_BIT]),
        .wr_data_in(apb_req_in.pwdata[CNT_W-1:0]),
        .count_out(t0_cnt),
        .max_out(t0_max),
        .mc_out(t0_mc),
        .wrap_out(t0_wrap)
    );

    pwd_timer u_t1 (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .event_in(t1_ev),
        .wr_cnt_in(wr_t1_cnt),
        .wr_max_in(wr_t1_max),
        .mc_clr_in(wr_t1_ctl & ~apb_req_in.pwdata[TCTL_MC_BIT]),
        .wr_data_in(apb_req_in.pwdata[CNT_W-1:0]),
        .count_out(t1_cnt),
        .max_out(t1_max),
        .mc_out(t1_mc),
        .wrap_out(t1_wrap)
    );

    // request sources: in demod the pulse pin drives both lines
    always_comb begin
        if (demod) begin
            low_end = rise[PIN_PULSE];
            high_end = fall[PIN_PULSE];
        end else begin
            low_end = rise[PIN_PULSE];
            high_end = rise[PIN_HI_IRQ];
        end
        req_set = '0;
        req_set[IRQ_LOW_END_BIT] = low_end;
        req_set[IRQ_HIGH_END_BIT] = high_end;
        req_set[IRQ_T0_MC_BIT] = t0_wrap & t0_ie_r;
        req_set[IRQ_T1_MC_BIT] = t1_wrap & t1_ie_r;
    end

    // apb decode
    always_comb begin
        start = apb_req_in.psel & apb_req_in.penable & ~rdy_r;
        acc = apb_req_in.psel & apb_req_in.penable & rdy_r;
        wr = acc & apb_req_in.pwrite;
        hit = 1'b1;
        rd_mux = DATA_ZERO;
        if (apb_req_in.paddr == OFF_SYS_CFG) begin
            rd_mux[CFG_DEMOD_BIT] = cfg_r;
        end else if (apb_req_in.paddr == OFF_T0_CNT) begin
            rd_mux[CNT_W-1:0] = t0_cnt;
        end else if (apb_req_in.paddr == OFF_T0_MAX) begin
            rd_mux[CNT_W-1:0] = t0_max;
        end else if (apb_req_in.paddr == OFF_T0_CTL) begin
            rd_mux[TCTL_INT_EN_BIT] = t0_ie_r;
            rd_mux[TCTL_MC_BIT] = t0_mc;
        end else if (apb_req_in.paddr == OFF_T1_CNT) begin
            rd_mux[CNT_W-1:0] = t1_cnt;
        end else if (apb_req_in.paddr == OFF_T1_MAX) begin
            rd_mux[CNT_W-1:0] = t1_max;
        end else if (apb_req_in.paddr == OFF_T1_CTL) begin
            rd_mux[TCTL_INT_EN_BIT] = t1_ie_r;
            rd_mux[TCTL_MC_BIT] = t1_mc;
        end else if (apb_req_in.paddr == OFF_IRQ_REQ) begin
            rd_mux[IRQ_W-1:0] = req_r;
        end else if (apb_req_in.paddr == OFF_IRQ_MASK) begin
            rd_mux[IRQ_W-1:0] = mask_r;
        end else if (apb_req_in.paddr == OFF_PIO_IN) begin
            rd_mux[PIO_W-1:0] = pio_r;
        end else begin
            hit = 1'b0;
        end
        wr_t0_cnt = wr & hit & (apb_req_in.paddr == OFF_T0_CNT);
        wr_t0_max = wr & hit & (apb_req_in.paddr == OFF_T0_MAX);
        wr_t0_ctl = wr & hit & (apb_req_in.paddr == OFF_T0_CTL);
        wr_t1_cnt = wr & hit & (apb_req_in.paddr == OFF_T1_CNT);
        wr_t1_max = wr & hit & (apb_req_in.paddr == OFF_T1_MAX);
        wr_t1_ctl = wr & hit & (apb_req_in.paddr == OFF_T1_CTL);
    end

    // registers, request and bus answer
    always_comb begin
        cfg_nxt = cfg_r;
        t0_ie_nxt = t0_ie_r;
        t1_ie_nxt = t1_ie_r;
        mask_nxt = mask_r;
        req_nxt = req_r;
        rdy_nxt = start;
        // error stands only beside ready, so pslverr needs no gate after its flop
        err_nxt = 1'b0;
        rdata_nxt = rdata_r;
        if (start) begin
            // answer data is frozen one cycle early; the read clear uses it
            rdata_nxt = apb_req_in.pwrite ? DATA_ZERO : rd_mux;
            err_nxt = ~hit;
        end
        if (wr & hit) begin
            if (apb_req_in.paddr == OFF_SYS_CFG) begin
                cfg_nxt = apb_req_in.pwdata[CFG_DEMOD_BIT];
            end else if (apb_req_in.paddr == OFF_T0_CTL) begin
                t0_ie_nxt = apb_req_in.pwdata[TCTL_INT_EN_BIT];
            end else if (apb_req_in.paddr == OFF_T1_CTL) begin
                t1_ie_nxt = apb_req_in.pwdata[TCTL_INT_EN_BIT];
            end else if (apb_req_in.paddr == OFF_IRQ_MASK) begin
                mask_nxt = apb_req_in.pwdata[IRQ_W-1:0];
            end
        end
        // only bits already returned are cleared; a new set wins
        if (acc & ~apb_req_in.pwrite & (apb_req_in.paddr == OFF_IRQ_REQ)) begin
            req_nxt = req_r & ~rdata_r[IRQ_W-1:0];
        end
        req_nxt = req_nxt | req_set;
        irq_nxt = |(req_r & mask_r);
        pio_nxt = demod ? {lvl[PIN_HI_IRQ], lvl[PIN_T1], lvl[PIN_T0]} : '0;
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cfg_r <= 1'b0;
            t0_ie_r <= 1'b0;
            t1_ie_r <= 1'b0;
            mask_r <= IRQ_RST;
            req_r <= IRQ_RST;
            irq_r <= 1'b0;
            rdy_r <= 1'b0;
            err_r <= 1'b0;
            rdata_r <= DATA_ZERO;
            pio_r <= '0;
        end else begin
            cfg_r <= cfg_nxt;
            t0_ie_r <= t0_ie_nxt;
            t1_ie_r <= t1_ie_nxt;
            mask_r <= mask_nxt;
            req_r <= req_nxt;
            irq_r <= irq_nxt;
            rdy_r <= rdy_nxt;
            err_r <= err_nxt;
            rdata_r <= rdata_nxt;
            pio_r <= pio_nxt;
        end
    end

    assign apb_rsp_out.pready = rdy_r;
    assign apb_rsp_out.pslverr = err_r;
    assign apb_rsp_out.prdata = rdata_r;
    assign irq_out = irq_r;
    assign demod_active_out = cfg_r;
    assign programmable_io_free_out = {PIO_W{cfg_r}};

    // checks
    tick_quarter_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        tick_r |=> !tick_r [*3] ##1 tick_r)
        else $error("timer tick not every fourth cycle");
    high_gate_t0_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (demod && !lvl[PIN_PULSE] && !wr_t0_cnt) |=> (t0_cnt == $past(t0_cnt)))
        else $error("timer 0 counted while pulse low");
    low_gate_t1_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (demod && lvl[PIN_PULSE] && !wr_t1_cnt) |=> (t1_cnt == $past(t1_cnt)))
        else $error("timer 1 counted while pulse high");
    count_on_tick_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (t0_cnt != $past(t0_cnt)) |-> ($past(tick_r) || $past(wr_t0_cnt)))
        else $error("timer 0 moved off the quarter-rate tick");
    rise_ends_low_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (demod && rise[PIN_PULSE]) |=> req_r[IRQ_LOW_END_BIT])
        else $error("rising pulse edge missed low-end request");
    fall_ends_high_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (demod && fall[PIN_PULSE]) |=> req_r[IRQ_HIGH_END_BIT])
        else $error("falling pulse edge missed high-end request");
    pin_freed_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (demod && $stable(cfg_r) && !fall[PIN_PULSE] && !(acc && !apb_req_in.pwrite))
            |=> $stable(req_r[IRQ_HIGH_END_BIT]))
        else $error("freed irq pin still raised a request");
    max_req_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (t0_wrap && t0_ie_r) |=> req_r[IRQ_T0_MC_BIT])
        else $error("timer 0 max count request missing");
    pin_lag_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (demod && $rose(pulse_pin_in)) |-> ##[1:6] (tick_r ? lvl[PIN_PULSE] : 1'b1) ##0 lvl[PIN_PULSE])
        else $error("pulse level reached timer gate too late");
    irq_follows_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (|(req_r & mask_r)) |=> irq_r)
        else $error("interrupt output missed unmasked request");
    max_req_t1_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (t1_wrap && t1_ie_r) |=> req_r[IRQ_T1_MC_BIT])
        else $error("timer 1 max count request missing");
    t1_on_tick_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (t1_cnt != $past(t1_cnt)) |-> ($past(tick_r) || $past(wr_t1_cnt)))
        else $error("timer 1 moved off the quarter-rate tick");
    high_count_t0_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (demod && tick_r && lvl[PIN_PULSE] && !wr_t0_cnt && (t0_cnt + 16'h0001 != t0_max))
            |=> (t0_cnt == $past(t0_cnt) + 16'h0001))
        else $error("timer 0 did not count while pulse high");
    low_count_t1_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (demod && tick_r && !lvl[PIN_PULSE] && !wr_t1_cnt && (t1_cnt + 16'h0001 != t1_max))
            |=> (t1_cnt == $past(t1_cnt) + 16'h0001))
        else $error("timer 1 did not count while pulse low");

    // normal functions stay while demod is off; freed pins stay quiet while it is on
    ext_edge_kept_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (!demod && !tick_r && rise[PIN_T0]) |=> pend0_r)
        else $error("external timer 0 edge lost in normal mode");
    irq_pin_kept_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (!demod && rise[PIN_HI_IRQ]) |=> req_r[IRQ_HIGH_END_BIT])
        else $error("irq pin rise lost in normal mode");
    low_rise_kept_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (!demod && rise[PIN_PULSE]) |=> req_r[IRQ_LOW_END_BIT])
        else $error("pulse pin rise lost in normal mode");
    cfg_hold_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        !(wr && hit && (apb_req_in.paddr == OFF_SYS_CFG)) |=> $stable(cfg_r))
        else $error("demod enable changed without a config write");
    ext_pend_dropped_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        demod |=> (!pend0_r && !pend1_r))
        else $error("freed timer input still pending a count");
    pio_levels_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        demod |=> (pio_r == $past({lvl[PIN_HI_IRQ], lvl[PIN_T1], lvl[PIN_T0]})))
        else $error("freed pin levels not shown");
    pio_zero_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        !demod |=> (pio_r == '0))
        else $error("pin levels shown outside demod");
    read_clear_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (acc && !apb_req_in.pwrite && (apb_req_in.paddr == OFF_IRQ_REQ) && (req_set == IRQ_RST))
            |=> ((req_r & $past(rdata_r[IRQ_W-1:0])) == IRQ_RST))
        else $error("returned request bits not cleared");
    slow_req_stays_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        (req_r[IRQ_T0_MC_BIT] && !(acc && !apb_req_in.pwrite && (apb_req_in.paddr == OFF_IRQ_REQ)))
            |=> req_r[IRQ_T0_MC_BIT])
        else $error("request bit dropped before it was read");
    irq_quiet_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
        ((req_r & mask_r) == IRQ_RST) |=> !irq_r)
        else $error("interrupt output high with no unmasked request");
endmodule : pwd_top
`default_nettype wire

// *** tb/pwd_pulse_src.sv ***
// behavioural pulse source standing in for a bar-code reader
`timescale 1ns/1ps
`default_nettype none
module pwd_pulse_src (
    // clock
    input wire logic clock_in,
    // pulse line
    output logic pulse_out
);
    logic pulse_r = 1'b0;

    assign pulse_out = pulse_r;

    // a phase starts just after an edge and holds for whole cycles, like a real reader
    task automatic drive(input logic lvl, input int cyc);
        @(posedge clock_in);
        pulse_r <= lvl;
        repeat (cyc - 1) @(posedge clock_in);
    endtask : drive
endmodule : pwd_pulse_src
`default_nettype wire

// *** tb/pulse_width_demodulator_tb.sv ***
// self-checking bench for the pulse-width demodulator
`timescale 1ns/1ps
`default_nettype none
module pulse_width_demodulator_tb;
    import pwd_pkg::*;
    logic clock_in = 1'b0;
    logic rst_n_in = 1'b0;
    pwd_apb_req_s req = '0;
    pwd_apb_rsp_s rsp;
    logic t0_in = 1'b0;
    logic t1_in = 1'b0;
    logic hi_irq = 1'b0;
    logic pulse;
    logic irq;
    logic demod;
    logic [PIO_W-1:0] pio_free;
    logic [DATA_W-1:0] rd;
    logic err;
    int err_count = 0;
    int compares = 0;
    int i;

    always #2.5 clock_in = ~clock_in;

    pwd_pulse_src src (.clock_in(clock_in), .pulse_out(pulse));

    pwd_top dut (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .apb_req_in(req),
        .apb_rsp_out(rsp),
        .pulse_pin_in(pulse),
        .timer_zero_ext_input_in(t0_in),
        .timer_one_ext_input_in(t1_in),
        .high_phase_end_irq_in(hi_irq),
        .irq_out(irq),
        .demod_active_out(demod),
        .programmable_io_free_out(pio_free)
    );

    task automatic summarize;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : summarize

    // range compare; an unknown never lands inside the range
    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] lo,
                       input logic [DATA_W-1:0] hi, input string what);
        compares++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            err_count++;
            $display("[FAIL] %0t %s: got %h want %h..%h", $time, what, got, lo, hi);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd);
        int n;
        @(posedge clock_in);
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= wr;
        req.paddr <= a;
        req.pwdata <= wd;
        @(posedge clock_in);
        req.penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge clock_in);
            if (rsp.pready === 1'b1) break;
        end
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        if (n == 16) begin
            err_count++;
            $display("[FAIL] %0t no bus answer", $time);
            summarize();
        end
    endtask : apb

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] lo,
                        input logic [DATA_W-1:0] hi, input string what);
        apb(1'b0, a, DATA_ZERO);
        chk(rd, lo, hi, what);
    endtask : rchk

    initial begin
        repeat (6) @(posedge clock_in);
        rst_n_in <= 1'b1;
        chk(DATA_W'(irq), 0, 0, "irq at reset");
        rchk(OFF_SYS_CFG, 0, 0, "config reset");
        rchk(OFF_T0_MAX, 0, 0, "t0 max reset");
        apb(1'b1, 8'h28, 32'hffff_ffff);
        chk(DATA_W'(err), 1, 1, "unmapped write error");
        apb(1'b0, 8'h28, DATA_ZERO);
        chk(DATA_W'(err), 1, 1, "unmapped read error");
        chk(rd, 0, 0, "unmapped read data");
        $display("test reset done");

        // normal mode: external inputs count edges, pins raise their own requests
        rchk(OFF_IRQ_REQ, 0, 0, "no request yet");
        repeat (3) begin
            @(posedge clock_in);
            t0_in <= 1'b1;
            t1_in <= 1'b1;
            repeat (8) @(posedge clock_in);
            t0_in <= 1'b0;
            t1_in <= 1'b0;
            repeat (8) @(posedge clock_in);
        end
        rchk(OFF_T0_CNT, 3, 3, "t0 external edges");
        rchk(OFF_T1_CNT, 3, 3, "t1 external edges");
        src.drive(1'b1, 12);
        src.drive(1'b0, 12);
        chk(DATA_W'(irq), 0, 0, "masked request quiet");
        rchk(OFF_IRQ_REQ, 1, 1, "pin rise only");
        @(posedge clock_in);
        hi_irq <= 1'b1;
        repeat (10) @(posedge clock_in);
        rchk(OFF_IRQ_REQ, 2, 2, "irq pin rise");
        rchk(OFF_IRQ_REQ, 0, 0, "read clears");
        $display("test normal done");

        // demod on: reserved bits read zero, shared pins become plain inputs
        wr(OFF_SYS_CFG, 32'hffff_ffff);
        rchk(OFF_SYS_CFG, 1, 1, "config readback");
        chk(DATA_W'(demod), 1, 1, "demod flag");
        chk(DATA_W'(pio_free), 7, 7, "pins freed");
        wr(OFF_T0_CNT, DATA_ZERO);
        @(posedge clock_in);
        t0_in <= 1'b1;
        hi_irq <= 1'b0;
        repeat (8) @(posedge clock_in);
        hi_irq <= 1'b1;
        repeat (12) @(posedge clock_in);
        rchk(OFF_T0_CNT, 0, 0, "t0 ignores pin");
        rchk(OFF_IRQ_REQ, 0, 0, "irq pin ignored");
        rchk(OFF_PIO_IN, 5, 5, "free pin levels");
        $display("test demod enable done");

        // one low phase and one high phase measured as software would
        wr(OFF_T0_CNT, DATA_ZERO);
        wr(OFF_IRQ_MASK, 32'h3);
        rchk(OFF_T0_CNT, 0, 0, "t0 still in low");
        wr(OFF_T1_CNT, DATA_ZERO);
        src.drive(1'b0, 40);
        fork
            src.drive(1'b1, 80);
            begin
                for (i = 0; i < 10; i++) begin
                    @(posedge clock_in);
                    if (irq === 1'b1) break;
                end
                chk(DATA_W'(irq), 1, 1, "rise interrupt");
                rchk(OFF_IRQ_REQ, 1, 1, "rise ends low");
                rchk(OFF_T1_CNT, 9, 12, "low width");
                wr(OFF_T1_CNT, DATA_ZERO);
            end
        join
        src.drive(1'b0, 12);
        rchk(OFF_IRQ_REQ, 2, 2, "fall ends high");
        rchk(OFF_T0_CNT, 19, 21, "high width");
        wr(OFF_T0_CNT, DATA_ZERO);
        $display("test measure done");

        // a high phase longer than the max count wraps timer 0; timer 1 wraps in the low gaps
        wr(OFF_T1_MAX, 32'h2);
        wr(OFF_T1_CTL, 32'h1);
        wr(OFF_T1_CNT, DATA_ZERO);
        wr(OFF_T0_MAX, 32'h4);
        wr(OFF_T0_CTL, 32'h1);
        wr(OFF_IRQ_MASK, 32'h4);
        src.drive(1'b1, 40);
        src.drive(1'b0, 12);
        chk(DATA_W'(irq), 1, 1, "overflow interrupt");
        rchk(OFF_T0_CTL, 3, 3, "max count flag");
        rchk(OFF_T1_CTL, 3, 3, "t1 max count flag");
        rchk(OFF_T0_CNT, 0, 3, "wrapped below max");
        rchk(OFF_IRQ_REQ, 15, 15, "edges and overflow");
        repeat (3) @(posedge clock_in);
        chk(DATA_W'(irq), 0, 0, "interrupt cleared");
        wr(OFF_T0_CTL, 32'h1);
        rchk(OFF_T0_CTL, 1, 1, "flag cleared");
        $display("test overflow done");
        summarize();
    end
endmodule : pulse_width_demodulator_tb
`default_nettype wire
